// ---- rtl/sarc_pkg.sv ----
// constants and types for the sar converter control block
// Contract
// - converter runs only while converter_on is 1; otherwise idle, no conversions
// - differential code 0000b measures pin0 minus pin1; 0001b the opposite
// - left_align_sel 0 right-justifies the result, 1 left-justifies it
// - single-ended results are 10-bit unsigned: full scale 0x03FF or 0xFFC0
// - single-ended spare result bits read zero in both justifications
// - differential results are two's complement, right-justified sign-extended
// - differential left-justified: spare low bits zero, 0x7FC0 to 0x8000
// - sar clock is system clock divided by sar_clock_divider plus one
// - start_source_sel picks software, timer-3, strobe or timer-2 start
// - strobe source starts a conversion on each synchronous rising edge
// - conv_in_progress is 1 throughout a conversion, 0 when it ends
// - end of conversion sets conv_done_flag and, if enabled, the interrupt
// - result bytes are valid when conv_done_flag reads 1
// - timer start uses low-byte overflow in 8-bit, high-byte in 16-bit mode
// - low-power track: 3 sar clocks tracking after start; else track always; the code stops tracking during conversion
// - code 10 is strobe; low-power tracks while strobe low, converts on rise
// - conv_done_flag stays set until software clears it
package sarc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG  = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL = 8'h08;
  localparam logic [7:0] ADDR_PAIRS   = 8'h0C;
  localparam logic [7:0] ADDR_RESULT  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_CLEAR   = 8'h18;
  localparam logic [7:0] ADDR_ENABLE  = 8'h1C;
  // ==========================================================
  // control and config register fields
  localparam int CTL_ON    = 7;
  localparam int CTL_LPT   = 6;
  localparam int CTL_DONE  = 5;
  localparam int CTL_BUSY  = 4;
  localparam int CTL_SRC_H = 3;
  localparam int CTL_SRC_L = 2;
  localparam int CTL_LEFT  = 0;
  localparam int CFG_DIV_H = 7;
  localparam int CFG_DIV_L = 3;
  localparam logic [4:0] DIV_RESET = 5'h1F;
  // ==========================================================
  // start sources, bus responses, track length and sequencer states
  localparam logic [1:0] SRC_SOFT  = 2'h0;
  localparam logic [1:0] SRC_TMR3  = 2'h1;
  localparam logic [1:0] SRC_STROBE = 2'h2;
  localparam logic [1:0] SRC_TMR2  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int TRACK_TICKS = 3;
  typedef enum logic [2:0] {
    SARC_IDLE  = 3'b001,
    SARC_TRACK = 3'b010,
    SARC_CONV  = 3'b100
  } sarc_state_t;
endpackage

// ---- rtl/sarc_top.sv ----
// sar converter control: start, clocking, approximation, result and bus
`timescale 1ns/1ps
module sarc_top #(
  parameter int RES_BITS    = 10,
  parameter int TRACK_COUNT = sarc_pkg::TRACK_TICKS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        timer3_low_ovf,
  input  wire logic        timer3_high_ovf,
  input  wire logic        timer3_16bit,
  input  wire logic        timer2_low_ovf,
  input  wire logic        timer2_high_ovf,
  input  wire logic        timer2_16bit,
  input  wire logic        external_convert_strobe,
  input  wire logic        cmp_in,
  output logic [9:0]       dac_code,
  output logic             track_en,
  output logic             analog_power,
  output logic [2:0]       mux_pos,
  output logic [2:0]       mux_neg,
  output logic             diff_mode,
  output logic             temp_sel,
  output logic             irq
);
  if (RES_BITS != 10) begin : res_check
    $error("only a 10-bit core is served");
  end
  if (TRACK_COUNT < 1 || TRACK_COUNT > 15) begin : trk_check
    $error("bad track count");
  end

  // ==========================================================
  // result formatting
  function automatic logic [15:0] fmt(input logic [9:0] c,
                                      input logic d, input logic l);
    logic [9:0] v;
    v = d ? {~c[9], c[8:0]} : c;
    if (l) fmt = {v, 6'h00};
    else if (d) fmt = {{6{v[9]}}, v};
    else fmt = {6'h00, v};
  endfunction

  // ==========================================================
  // software-visible state
  logic        converter_on, low_power_track_sel, left_align_sel;
  logic [1:0]  start_source_sel;
  logic [4:0]  sar_clock_divider;
  logic [3:0]  channel_select, pair_diff;
  logic [15:0] result;
  logic        conv_done_flag, irq_enable;
  sarc_pkg::sarc_state_t state;
  logic        busy;
  assign busy = (state != sarc_pkg::SARC_IDLE);

  // ==========================================================
  // bus slave
  logic        aw_got, w_got, have_aw, have_w, do_write, ar_take;
  logic [7:0]  aw_addr, waddr;
  logic [31:0] w_data, wdat;
  logic        w_lane0;
  assign have_aw  = aw_got | (s_axi_awvalid & s_axi_awready);
  assign have_w   = w_got | (s_axi_wvalid & s_axi_wready);
  assign do_write = have_aw & have_w & ~s_axi_bvalid;
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign waddr = aw_got ? aw_addr : s_axi_awaddr;
  assign wdat  = w_got ? w_data : s_axi_wdata;
  logic [3:0] w_strb;
  assign w_lane0 = w_got ? w_strb[0] : s_axi_wstrb[0];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == sarc_pkg::ADDR_CONTROL) || (a == sarc_pkg::ADDR_CONFIG)
          || (a == sarc_pkg::ADDR_CHANNEL) || (a == sarc_pkg::ADDR_PAIRS)
          || (a == sarc_pkg::ADDR_RESULT)  || (a == sarc_pkg::ADDR_STATUS)
          || (a == sarc_pkg::ADDR_CLEAR)   || (a == sarc_pkg::ADDR_ENABLE);
  endfunction

  logic wr_ctl, wr_cfg, wr_chn, wr_par, wr_clr, wr_ena;
  assign wr_ctl = do_write & w_lane0 & (waddr == sarc_pkg::ADDR_CONTROL);
  assign wr_cfg = do_write & w_lane0 & (waddr == sarc_pkg::ADDR_CONFIG);
  assign wr_chn = do_write & w_lane0 & (waddr == sarc_pkg::ADDR_CHANNEL);
  assign wr_par = do_write & w_lane0 & (waddr == sarc_pkg::ADDR_PAIRS);
  assign wr_clr = do_write & w_lane0 & (waddr == sarc_pkg::ADDR_CLEAR);
  assign wr_ena = do_write & w_lane0 & (waddr == sarc_pkg::ADDR_ENABLE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sarc_pkg::RESP_OKAY;
    end else begin
      aw_got <= have_aw & ~do_write;
      w_got  <= have_w & ~do_write;
      if (s_axi_awvalid & s_axi_awready) aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~(have_aw & ~do_write);
      s_axi_wready  <= ~(have_w & ~do_write);
      s_axi_bvalid  <= do_write | (s_axi_bvalid & ~s_axi_bready);
      if (do_write) begin
        s_axi_bresp <= mapped(waddr) ? sarc_pkg::RESP_OKAY
                                     : sarc_pkg::RESP_SLVERR;
      end
    end
  end

  logic [7:0] ctl_view;
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[sarc_pkg::CTL_ON]   = converter_on;
    ctl_view[sarc_pkg::CTL_LPT]  = low_power_track_sel;
    ctl_view[sarc_pkg::CTL_DONE] = conv_done_flag;
    ctl_view[sarc_pkg::CTL_BUSY] = busy;
    ctl_view[sarc_pkg::CTL_SRC_H:sarc_pkg::CTL_SRC_L] = start_source_sel;
    ctl_view[sarc_pkg::CTL_LEFT] = left_align_sel;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sarc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
      s_axi_rvalid  <= ar_take | (s_axi_rvalid & ~s_axi_rready);
      if (ar_take) begin
        s_axi_rresp <= sarc_pkg::RESP_OKAY;
        if (s_axi_araddr == sarc_pkg::ADDR_CONTROL)
          s_axi_rdata <= {24'h000000, ctl_view};
        else if (s_axi_araddr == sarc_pkg::ADDR_CONFIG)
          s_axi_rdata <= {24'h000000, sar_clock_divider, 3'h0};
        else if (s_axi_araddr == sarc_pkg::ADDR_CHANNEL)
          s_axi_rdata <= {28'h0000000, channel_select};
        else if (s_axi_araddr == sarc_pkg::ADDR_PAIRS)
          s_axi_rdata <= {28'h0000000, pair_diff};
        else if (s_axi_araddr == sarc_pkg::ADDR_RESULT)
          s_axi_rdata <= {16'h0000, result};
        else if (s_axi_araddr == sarc_pkg::ADDR_STATUS)
          s_axi_rdata <= {31'h00000000, conv_done_flag};
        else if (s_axi_araddr == sarc_pkg::ADDR_ENABLE)
          s_axi_rdata <= {31'h00000000, irq_enable};
        else if (s_axi_araddr == sarc_pkg::ADDR_CLEAR)
          s_axi_rdata <= 32'h0000_0000;
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= sarc_pkg::RESP_SLVERR;
        end
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_on        <= 1'b0;
      low_power_track_sel <= 1'b0;
      start_source_sel    <= sarc_pkg::SRC_SOFT;
      left_align_sel      <= 1'b0;
      sar_clock_divider   <= sarc_pkg::DIV_RESET;
      channel_select      <= 4'h0;
      pair_diff           <= 4'h0;
      irq_enable          <= 1'b0;
    end else begin
      if (wr_ctl) begin
        converter_on        <= wdat[sarc_pkg::CTL_ON];
        low_power_track_sel <= wdat[sarc_pkg::CTL_LPT];
        start_source_sel <= wdat[sarc_pkg::CTL_SRC_H:sarc_pkg::CTL_SRC_L];
        left_align_sel      <= wdat[sarc_pkg::CTL_LEFT];
      end
      if (wr_cfg)
        sar_clock_divider <= wdat[sarc_pkg::CFG_DIV_H:sarc_pkg::CFG_DIV_L];
      if (wr_chn) channel_select <= wdat[3:0];
      if (wr_par) pair_diff <= wdat[3:0];
      if (wr_ena) irq_enable <= wdat[0];
    end
  end

  // ==========================================================
  // start sources
  logic strobe_prev, strobe_rise, tmr3_ovf, tmr2_ovf, start_evt;
  assign strobe_rise = external_convert_strobe & ~strobe_prev;
  assign tmr3_ovf = timer3_16bit ? timer3_high_ovf : timer3_low_ovf;
  assign tmr2_ovf = timer2_16bit ? timer2_high_ovf : timer2_low_ovf;
  always_comb begin
    case (start_source_sel)
      sarc_pkg::SRC_SOFT:   start_evt = wr_ctl & wdat[sarc_pkg::CTL_BUSY];
      sarc_pkg::SRC_TMR3:   start_evt = tmr3_ovf;
      sarc_pkg::SRC_STROBE: start_evt = strobe_rise;
      default:              start_evt = tmr2_ovf;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) strobe_prev <= 1'b0;
    else strobe_prev <= external_convert_strobe;
  end

  // ==========================================================
  // sar clock divider: one tick every divider+1 system clocks
  logic [4:0] div_cnt;
  logic       tick;
  assign tick = converter_on & (div_cnt == sar_clock_divider);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) div_cnt <= 5'h00;
    else if (!converter_on || tick || state == sarc_pkg::SARC_IDLE)
      div_cnt <= 5'h00;
    else div_cnt <= div_cnt + 5'h01;
  end

  // ==========================================================
  // conversion sequencer
  logic [3:0] trk_cnt, bit_idx;
  logic [9:0] code;
  logic       finish, ch_diff, strobe_lp;
  assign ch_diff = ~channel_select[3] & pair_diff[channel_select[2:1]];
  assign finish  = (state == sarc_pkg::SARC_CONV) & tick
                 & (bit_idx == 4'h0);
  // strobe in low-power mode has tracked while low; the edge converts
  assign strobe_lp = (start_source_sel == sarc_pkg::SRC_STROBE);
  // dac_code moves on the same edge as code: with divider 0 the
  // comparator must already show the trial that the next tick judges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= sarc_pkg::SARC_IDLE;
      trk_cnt  <= 4'h0;
      bit_idx  <= 4'h0;
      code     <= 10'h000;
      dac_code <= 10'h000;
    end else if (!converter_on) begin
      state <= sarc_pkg::SARC_IDLE;
    end else begin
      case (state)
        sarc_pkg::SARC_IDLE: begin
          if (start_evt) begin
            if (low_power_track_sel && !strobe_lp) begin
              state   <= sarc_pkg::SARC_TRACK;
              trk_cnt <= 4'h0;
            end else begin
              state    <= sarc_pkg::SARC_CONV;
              bit_idx  <= 4'h9;
              code     <= 10'h200;
              dac_code <= 10'h200;
            end
          end
        end
        sarc_pkg::SARC_TRACK: begin
          if (tick) begin
            if (trk_cnt == 4'(TRACK_COUNT - 1)) begin
              state    <= sarc_pkg::SARC_CONV;
              bit_idx  <= 4'h9;
              code     <= 10'h200;
              dac_code <= 10'h200;
            end else trk_cnt <= trk_cnt + 4'h1;
          end
        end
        sarc_pkg::SARC_CONV: begin
          if (tick) begin
            if (!cmp_in) begin
              code[bit_idx]     <= 1'b0;
              dac_code[bit_idx] <= 1'b0;
            end
            if (bit_idx == 4'h0) state <= sarc_pkg::SARC_IDLE;
            else begin
              code[bit_idx - 4'h1]     <= 1'b1;
              dac_code[bit_idx - 4'h1] <= 1'b1;
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        default: state <= sarc_pkg::SARC_IDLE;
      endcase
    end
  end

  // result is written on the same edge that raises the flag
  logic [9:0] final_code;
  always_comb begin
    final_code = code;
    if (!cmp_in) final_code[0] = 1'b0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) result <= 16'h0000;
    else if (finish && converter_on)
      result <= fmt(final_code, ch_diff, left_align_sel);
  end

  // ==========================================================
  // done flag and interrupt; set wins over a clear in the same cycle
  logic next_flag, next_ena;
  assign next_flag = (finish & converter_on)
                   | (conv_done_flag & ~(wr_clr & wdat[0]));
  assign next_ena = wr_ena ? wdat[0] : irq_enable;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_done_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      conv_done_flag <= next_flag;
      irq <= next_flag & next_ena;
    end
  end

  // ==========================================================
  // analog side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      track_en <= 1'b0;
      analog_power <= 1'b0;
      mux_pos <= 3'h0;
      mux_neg <= 3'h0;
      diff_mode <= 1'b0;
      temp_sel <= 1'b0;
    end else begin
      analog_power <= converter_on;
      if (!converter_on) track_en <= 1'b0;
      else if (low_power_track_sel) begin
        if (strobe_lp) track_en <= ~busy & ~external_convert_strobe;
        else track_en <= (state == sarc_pkg::SARC_TRACK);
      end else track_en <= (state != sarc_pkg::SARC_CONV);
      mux_pos   <= channel_select[2:0];
      mux_neg   <= {channel_select[2:1], ~channel_select[0]};
      diff_mode <= ch_diff;
      temp_sel  <= channel_select[3];
    end
  end

  // ==========================================================
  // checks
  off_no_conv_a: assert property (@(posedge clk) disable iff (!arst_n)
    !converter_on |=> !busy) else $error("busy while off");
  fmt_se_a: assert property (@(posedge clk) disable iff (!arst_n)
    finish && !ch_diff && !left_align_sel |=> result[15:10] == 6'h00)
    else $error("single-ended high bits not zero");
  fmt_left_a: assert property (@(posedge clk) disable iff (!arst_n)
    finish && left_align_sel |=> result[5:0] == 6'h00)
    else $error("left result low bits not zero");
  sign_ext_a: assert property (@(posedge clk) disable iff (!arst_n)
    finish && ch_diff && !left_align_sel
    |=> result[15:10] == {6{result[9]}})
    else $error("sign extension wrong");
  // spacing is checked only at divider 8, which t_format and most of t_starts run with
  tick_rate_a: assert property (@(posedge clk)
    disable iff (!arst_n || !converter_on)
    tick && !finish && sar_clock_divider == 5'h08
    && $stable(sar_clock_divider) |=> !tick [*8] ##1 tick)
    else $error("sar tick spacing wrong");
  busy_done_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(busy) && $past(converter_on) |-> conv_done_flag)
    else $error("flag not set at end");
  flag_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    conv_done_flag && !(wr_clr && wdat[0]) |=> conv_done_flag)
    else $error("flag dropped without clear");
  strobe_go_a: assert property (@(posedge clk) disable iff (!arst_n)
    strobe_rise && strobe_lp && converter_on && !busy
    |=> state == sarc_pkg::SARC_CONV) else $error("strobe missed");
  track_len_a: assert property (@(posedge clk)
    disable iff (!arst_n || !converter_on)
    $rose(state == sarc_pkg::SARC_TRACK) && sar_clock_divider == 5'h08
    && TRACK_COUNT == 3 |-> ##26 state == sarc_pkg::SARC_TRACK
    ##1 state == sarc_pkg::SARC_CONV) else $error("track length");
  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    irq == (conv_done_flag && irq_enable))
    else $error("irq not matching flag and enable");
endmodule

// ---- verification/sarc_analog_model.sv ----
// far-side model: track-and-hold input level and sar comparator
`timescale 1ns/1ps
module sarc_analog_model (
  input  wire logic       clk,
  input  wire logic [9:0] level,
  input  wire logic [9:0] dac_code,
  input  wire logic       track_en,
  input  wire logic       analog_power,
  output logic            cmp_in
);
  logic [9:0] held = 10'h000;
  logic       junk = 1'b0;
  // ==========================================================
  // hold capacitor
  // level changes after tracking ends must not reach the result
  always_ff @(posedge clk) begin
    if (track_en) begin
      held <= level;
    end
    junk <= ~junk;
  end
  // an unpowered comparator gives no steady answer
  assign cmp_in = analog_power ? (held >= dac_code) : junk;
endmodule

// ---- verification/sarc_top_bench.sv ----
// self-checking bench for the sar converter control block
`timescale 1ns/1ps
module sarc_top_bench;
  logic        clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, cmp_in, irq;
  logic        timer3_low_ovf, timer3_high_ovf, timer3_16bit, temp_sel;
  logic        timer2_low_ovf, timer2_high_ovf, timer2_16bit, diff_mode;
  logic        external_convert_strobe, track_en, analog_power;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [9:0]  dac_code, level;
  logic [2:0]  mux_pos, mux_neg;
  int          err_total, check_count, base, n;

  sarc_top dut_u (
    .clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .timer3_low_ovf, .timer3_high_ovf,
    .timer3_16bit, .timer2_low_ovf, .timer2_high_ovf, .timer2_16bit,
    .external_convert_strobe, .cmp_in, .dac_code, .track_en,
    .analog_power, .mux_pos, .mux_neg, .diff_mode, .temp_sel, .irq
  );
  sarc_analog_model ana_u (
    .clk, .level, .dac_code, .track_en, .analog_power, .cmp_in
  );

  // ==========================================================
  // verdict and comparison
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok = 1'b0;
    bit w_ok = 1'b0;
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask

  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  function automatic logic [15:0] fmt(input logic [9:0] c,
                                      input logic df, input logic lf);
    if (lf) return {c, 6'h00};
    return df ? {{6{c[9]}}, c} : {6'h00, c};
  endfunction

  // software start, then poll the flag rather than the busy bit
  task automatic conv(input logic [7:0] ctl);
    wr(sarc_pkg::ADDR_CONTROL, {24'h0, ctl});
    wr(sarc_pkg::ADDR_CONTROL, {24'h0, ctl | 8'h10});
    do rdreg(sarc_pkg::ADDR_STATUS); while (rd[0] !== 1'b1);
    rdreg(sarc_pkg::ADDR_RESULT);
  endtask

  // counts edges from the start event until the interrupt shows
  task automatic timed(input int src);
    @(posedge clk);
    {timer3_high_ovf, external_convert_strobe, timer2_low_ovf} <=
      3'b100 >> (src - 1);
    @(posedge clk);
    {timer3_high_ovf, timer2_low_ovf} <= 2'b00;
    n = 1;
    while (irq !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    external_convert_strobe <= 1'b0;
    wr(sarc_pkg::ADDR_CLEAR, 32'h1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rdreg(sarc_pkg::ADDR_CONFIG);
    check(rd, 32'hF8);
    rdreg(8'h40);
    check({rd[29:0], rs}, {30'h0, sarc_pkg::RESP_SLVERR});
    wr(8'h40, 32'hFF);
    check({30'h0, rs}, {30'h0, sarc_pkg::RESP_SLVERR});
    wr(sarc_pkg::ADDR_CONTROL, 32'h10);
    repeat (400) @(posedge clk);
    rdreg(sarc_pkg::ADDR_STATUS);
    check({rd[30:0], analog_power}, 32'h0);
    // divider 8 keeps the sar clock near 2.8 MHz
    wr(sarc_pkg::ADDR_CONFIG, 32'h47);
    rdreg(sarc_pkg::ADDR_CONFIG);
    check(rd, 32'h40);
  endtask

  task automatic t_format;
    logic [9:0] raw;
    for (int k = 0; k < 12; k++) begin
      raw = (k % 3 == 0) ? 10'h3FF : (k % 3 == 1) ? 10'h200 : 10'h000;
      if (k % 6 == 0) begin
        wr(sarc_pkg::ADDR_PAIRS, 32'(k / 6));
      end
      level <= raw;
      conv({1'b1, 6'h00, 1'(k / 3 % 2)});
      // core code is offset binary in differential mode
      check(rd, {16'h0, fmt(k >= 6 ? raw ^ 10'h200 : raw, k >= 6,
                            k / 3 % 2 == 1)});
      wr(sarc_pkg::ADDR_CLEAR, 32'h1);
    end
    check({25'h0, mux_pos, mux_neg, diff_mode}, 32'h3);
    wr(sarc_pkg::ADDR_CHANNEL, 32'h1);
    repeat (2) @(posedge clk);
    check({25'h0, mux_pos, mux_neg, diff_mode}, 32'h11);
    wr(sarc_pkg::ADDR_CHANNEL, 32'h8);
    repeat (2) @(posedge clk);
    check({24'h0, mux_pos, mux_neg, diff_mode, temp_sel}, 32'h05);
  endtask

  task automatic t_starts;
    wr(sarc_pkg::ADDR_ENABLE, 32'h1);
    wr(sarc_pkg::ADDR_CONTROL, 32'h84);
    timed(1);
    base = n;
    wr(sarc_pkg::ADDR_CONTROL, 32'hC4);
    @(posedge clk);
    check({31'h0, track_en}, 32'h0);
    timed(1);
    check(32'(n - base), 32'd27);
    wr(sarc_pkg::ADDR_CONTROL, 32'hC8);
    timed(2);
    check(32'(n), 32'(base));
    wr(sarc_pkg::ADDR_CONTROL, 32'h8C);
    timed(3);
    check(32'(n), 32'(base));
    wr(sarc_pkg::ADDR_CONFIG, 32'h48);
    wr(sarc_pkg::ADDR_CONTROL, 32'h84);
    timed(1);
    check(32'(n - base), 32'd10);
    @(posedge clk);
    {timer3_low_ovf, timer2_high_ovf, external_convert_strobe} <= 3'b111;
    @(posedge clk);
    {timer3_low_ovf, timer2_high_ovf, external_convert_strobe} <= 3'b000;
    repeat (300) @(posedge clk);
    rdreg(sarc_pkg::ADDR_STATUS);
    check(rd, 32'h0);
  endtask

  task automatic t_busy;
    wr(sarc_pkg::ADDR_CONFIG, 32'hF8);
    wr(sarc_pkg::ADDR_ENABLE, 32'h0);
    wr(sarc_pkg::ADDR_CONTROL, 32'h80);
    wr(sarc_pkg::ADDR_CONTROL, 32'h90);
    rdreg(sarc_pkg::ADDR_CONTROL);
    check(rd, 32'h90);
    repeat (400) @(posedge clk);
    rdreg(sarc_pkg::ADDR_CONTROL);
    check(rd, 32'hA0);
    check({31'h0, irq}, 32'h0);
    wr(sarc_pkg::ADDR_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(sarc_pkg::ADDR_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(sarc_pkg::ADDR_CONTROL, 32'h90);
    wr(sarc_pkg::ADDR_CONTROL, 32'h00);
    repeat (400) @(posedge clk);
    rdreg(sarc_pkg::ADDR_STATUS);
    check(rd, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the whole run needs some 3400 cycles
  initial begin
    #800_000;
    err_total++;
    stop_test();
  end

  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, timer3_low_ovf, timer3_high_ovf, timer2_low_ovf} = '0;
    {timer2_high_ovf, timer2_16bit, external_convert_strobe} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, level} = '0;
    timer3_16bit = 1'b1;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_format();
    t_starts();
    t_busy();
    stop_test();
  end
endmodule
